//--- lcm_pkg.sv
// Constants for the link capability and mailbox register group
// Operation
// - Capability register copied per port, selected
// - Bit 3 enables enhanced CRC, start
// - Bit 2 reports video checksum error
// - Bits 1-0 hold upper mode bits
// - Three-bit mode decodes normal, GPIO, SPI
// - Single-link devices allow normal modes only
// - Link detect drops when timer expires
// - Timeout field selects the expiry period
// - Mailbox A scratch, resets to a5
// - Mailbox B scratch, resets to 5a
// - Back channel loads fields unless frozen
package lcm_pkg;
  localparam logic [7:0] ADDR_CAP2 = 8'h21;
  localparam logic [7:0] ADDR_LINK_DET = 8'h26;
  localparam logic [7:0] ADDR_MAILBOX_A = 8'h2e;
  localparam logic [7:0] ADDR_MAILBOX_B = 8'h2f;
  localparam logic [7:0] RST_CAP2 = 8'h00;
  localparam logic [7:0] RST_LINK_DET = 8'h00;
  localparam logic [7:0] RST_MAILBOX_A = 8'ha5;
  localparam logic [7:0] RST_MAILBOX_B = 8'h5a;
  localparam int BIT_CRC = 3;
  localparam int BIT_CHK = 2;
  localparam logic [7:0] CAP2_WMASK = 8'h0b;
  localparam logic [7:0] LINK_DET_WMASK = 8'h07;
  // Mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_GPIO1 = 3'h1;
  localparam logic [2:0] MODE_GPIO2 = 3'h2;
  localparam logic [2:0] MODE_GPIO4 = 3'h3;
  localparam logic [2:0] MODE_FWD_SPI = 3'h6;
  localparam logic [2:0] MODE_REV_SPI = 3'h7;
  // Timeouts in ns as printed (code 011 kept at 1.3 ms)
  localparam longint CLK_NS = 8;
  localparam longint T0_NS = 162000000;
  localparam longint T1_NS = 325000000;
  localparam longint T2_NS = 650000000;
  localparam longint T3_NS = 1300000;
  localparam longint T4_NS = 10250;
  localparam longint T5_NS = 20500;
  localparam longint T6_NS = 41000;
  localparam longint T7_NS = 82000;
  // Codes 100 and 101 round down; the rest divide exactly
  localparam longint C0 = T0_NS / CLK_NS;
  localparam longint C1 = T1_NS / CLK_NS;
  localparam longint C2 = T2_NS / CLK_NS;
  localparam longint C3 = T3_NS / CLK_NS;
  localparam longint C4 = T4_NS / CLK_NS;
  localparam longint C5 = T5_NS / CLK_NS;
  localparam longint C6 = T6_NS / CLK_NS;
  localparam longint C7 = T7_NS / CLK_NS;
endpackage

//--- lcm_link_timer.sv
// Reverse-channel link-detect timer
module lcm_link_timer #(
  parameter logic [27:0] CNT0 = 28'(lcm_pkg::C0),
  parameter logic [27:0] CNT1 = 28'(lcm_pkg::C1),
  parameter logic [27:0] CNT2 = 28'(lcm_pkg::C2),
  parameter logic [27:0] CNT3 = 28'(lcm_pkg::C3),
  parameter logic [27:0] CNT4 = 28'(lcm_pkg::C4),
  parameter logic [27:0] CNT5 = 28'(lcm_pkg::C5),
  parameter logic [27:0] CNT6 = 28'(lcm_pkg::C6),
  parameter logic [27:0] CNT7 = 28'(lcm_pkg::C7)
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic [2:0] sel, // Timeout select
  input wire logic rx_valid, // Valid reverse-channel traffic
  output logic link_detect // Link detect indication
);
  logic [27:0] limit;
  logic [27:0] cnt_q, cnt_d;
  logic det_q, det_d;

  // Period table per select code
  always_comb begin
    unique case (sel)
      3'h0: limit = CNT0;
      3'h1: limit = CNT1;
      3'h2: limit = CNT2;
      3'h3: limit = CNT3;
      3'h4: limit = CNT4;
      3'h5: limit = CNT5;
      3'h6: limit = CNT6;
      3'h7: limit = CNT7;
    endcase
  end

  // Traffic restarts the count; silence for a full period drops detect
  always_comb begin
    cnt_d = cnt_q;
    det_d = det_q;
    if (rx_valid) begin
      cnt_d = 28'h0;
      det_d = 1'b1;
    end else if (cnt_q >= limit - 28'h1) begin
      det_d = 1'b0;
    end else begin
      cnt_d = cnt_q + 28'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 28'h0;
      det_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      det_q <= det_d;
    end
  end

  assign link_detect = det_q;
endmodule

//--- lcm_regs.sv
// Per-port capability, link-detect control and mailbox registers
module lcm_regs #(
  parameter bit DUAL_LINK = 1'b1, // Zero for single-link builds
  parameter logic [27:0] CNT0 = 28'(lcm_pkg::C0),
  parameter logic [27:0] CNT1 = 28'(lcm_pkg::C1),
  parameter logic [27:0] CNT2 = 28'(lcm_pkg::C2),
  parameter logic [27:0] CNT3 = 28'(lcm_pkg::C3)
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic second_port_select, // Host accesses port 1 copy
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, valid cycle after reg_rd
  input wire logic [1:0] bcc_load, // Per-port capability load strobe
  input wire logic [3:0] bcc_cap2, // Loaded crc enable and mode bits 2:1
  input wire logic [1:0] capability_freeze, // Per-port freeze from companion
  input wire logic [1:0] chksum_err, // Per-port checksum error pulse
  input wire logic [1:0] mode_bit0, // Per-port mode bit 0 from companion
  input wire logic rx_valid, // Valid reverse-channel traffic
  output logic [1:0] enhanced_crc_enable, // Per-port enhanced CRC enable
  output logic [5:0] fast_control_channel_mode, // Port1 [5:3], port0 [2:0]
  output logic link_detect // Link detect indication
);
  // Per-port capability copies and their next values
  logic [7:0] cap2_q [2];
  logic [7:0] cap2_d [2];
  // Shared timeout select and scratch mailboxes
  logic [7:0] ldet_q, ldet_d;
  logic [7:0] mba_q, mba_d;
  logic [7:0] mbb_q, mbb_d;
  // Registered read data and registered per-port outputs
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] crc_q, crc_d;
  logic [5:0] mode_q, mode_d;
  // Offset decode, shared by the write and the read path
  logic sel_cap2;
  logic sel_ldet;
  logic sel_mba;
  logic sel_mbb;
  // Per-port views that feed the output registers
  logic [2:0] mode_raw [2];
  logic [2:0] mode_dec [2];
  logic crc_bit [2];
  // Link detect comes straight from the timer's own flip-flop
  logic det_w;
  // Index of the copy the host currently sees
  logic port;

  // Copy chosen by the host-side select level; shared registers ignore it
  assign port = second_port_select;

  // One compare per offset keeps the write and read decodes in step
  assign sel_cap2 = (reg_addr == lcm_pkg::ADDR_CAP2);
  assign sel_ldet = (reg_addr == lcm_pkg::ADDR_LINK_DET);
  assign sel_mba = (reg_addr == lcm_pkg::ADDR_MAILBOX_A);
  assign sel_mbb = (reg_addr == lcm_pkg::ADDR_MAILBOX_B);

  // One capability copy per port; software writes only the selected copy
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      logic hit;
      logic load_ok;
      logic [7:0] wr_merge;
      assign hit = reg_wr && sel_cap2 && (port == 1'(p));
      // Back channel refill is blocked while this port is frozen
      assign load_ok = bcc_load[p] && !capability_freeze[p];
      // Only bits 3, 1 and 0 take host data; bit 2 and the top nibble keep their value
      assign wr_merge = (cap2_q[p] & ~lcm_pkg::CAP2_WMASK)
                      | (reg_wdata & lcm_pkg::CAP2_WMASK);

      // Priority, lowest first: back-channel load, host write, checksum error.
      // A host write in the same cycle as a load wins, so software that has not
      // yet set the freeze bit still sees its own value land.
      always_comb begin
        cap2_d[p] = cap2_q[p];
        if (load_ok) begin
          cap2_d[p][lcm_pkg::BIT_CRC] = bcc_cap2[3];
          cap2_d[p][1:0] = bcc_cap2[1:0];
        end
        if (hit) begin
          cap2_d[p] = wr_merge;
        end
        // Checksum error is sticky and wins over any write
        if (chksum_err[p]) begin
          cap2_d[p][lcm_pkg::BIT_CHK] = 1'b1;
        end
        cap2_d[p][7:4] = 4'h0;
      end

      // Per-port copy; reset clears every field
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cap2_q[p] <= lcm_pkg::RST_CAP2;
        end else begin
          cap2_q[p] <= cap2_d[p];
        end
      end

      // Full mode code: companion bit 0 sits below the two stored upper bits
      assign mode_raw[p] = {cap2_q[p][1:0], mode_bit0[p]};
      assign crc_bit[p] = cap2_q[p][lcm_pkg::BIT_CRC];

      // Only the defined codes pass; single-link builds always run the normal
      // frame, and the reserved codes fall back to it rather than to a guess
      always_comb begin
        unique case (mode_raw[p])
          lcm_pkg::MODE_GPIO1,
          lcm_pkg::MODE_GPIO2,
          lcm_pkg::MODE_GPIO4,
          lcm_pkg::MODE_FWD_SPI,
          lcm_pkg::MODE_REV_SPI: begin
            mode_dec[p] = DUAL_LINK ? mode_raw[p] : lcm_pkg::MODE_NORMAL;
          end
          default: begin
            mode_dec[p] = lcm_pkg::MODE_NORMAL;
          end
        endcase
      end
    end
  endgenerate

  // Shared registers: only the three mapped offsets change anything
  always_comb begin
    ldet_d = ldet_q;
    mba_d = mba_q;
    mbb_d = mbb_q;
    // Only the three select bits exist; the upper bits are dropped here
    if (reg_wr && sel_ldet) begin
      ldet_d = reg_wdata & lcm_pkg::LINK_DET_WMASK;
    end
    // Mailboxes have no side effects; every bit is kept as written
    if (reg_wr && sel_mba) begin
      mba_d = reg_wdata;
    end
    if (reg_wr && sel_mbb) begin
      mbb_d = reg_wdata;
    end
  end

  // Shared storage; the mailboxes come out of reset with distinct patterns
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ldet_q <= lcm_pkg::RST_LINK_DET;
      mba_q <= lcm_pkg::RST_MAILBOX_A;
      mbb_q <= lcm_pkg::RST_MAILBOX_B;
    end else begin
      ldet_q <= ldet_d;
      mba_q <= mba_d;
      mbb_q <= mbb_d;
    end
  end

  // Read path: data is captured on the strobe and then held, so the host
  // may fetch it at any time before its next read
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (sel_cap2) begin
        rdata_d = cap2_q[port];
      end else if (sel_ldet) begin
        rdata_d = ldet_q;
      end else if (sel_mba) begin
        rdata_d = mba_q;
      end else if (sel_mbb) begin
        rdata_d = mbb_q;
      end else begin
        // Unmapped offsets return zero rather than stale data
        rdata_d = 8'h00;
      end
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pack the per-port views for the output registers
  always_comb begin
    crc_d = {crc_bit[1], crc_bit[0]};
    mode_d = {mode_dec[1], mode_dec[0]};
  end

  // Outputs are registered so each top-level pin leaves a flip-flop; they
  // therefore lag the stored capability by one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_q <= 2'h0;
      mode_q <= 6'h00;
    end else begin
      crc_q <= crc_d;
      mode_q <= mode_d;
    end
  end

  // Long periods are parameters so simulation can shorten them; the short
  // periods keep their true length in clock cycles, rounded down
  lcm_link_timer #(
    .CNT0(CNT0),
    .CNT1(CNT1),
    .CNT2(CNT2),
    .CNT3(CNT3)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .sel(ldet_q[2:0]),
    .rx_valid(rx_valid),
    .link_detect(det_w)
  );

  // Output pins, each fed by a flip-flop above or in the timer
  assign reg_rdata = rdata_q;
  assign enhanced_crc_enable = crc_q;
  assign fast_control_channel_mode = mode_q;
  assign link_detect = det_w;
endmodule

//--- lcm_regs_assertions.sv
// Port checks for the capability and mailbox registers
module lcm_regs_chk (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic second_port_select, // Port copy select
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic rx_valid, // Reverse-channel traffic
  input wire logic link_detect, // Link detect output
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [1:0] bcc_load, // Load strobes
  input wire logic [1:0] capability_freeze, // Freeze levels
  input wire logic [1:0] enhanced_crc_enable, // CRC enable outputs
  input wire logic [3:0] bcc_cap2, // Load value
  input wire logic [5:0] fast_control_channel_mode // Mode outputs
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic w3, l3, c0;
  // Single bits for history; outputs lag their registers by one cycle
  assign w3 = reg_wdata[3];
  assign l3 = bcc_cap2[3];
  assign c0 = enhanced_crc_enable[0];
  a_unmap_rd: assert property (reg_rd && !(reg_addr inside {8'h21, 8'h26, 8'h2e, 8'h2f})
    |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_cap_rsvd: assert property (reg_rd && reg_addr == 8'h21 |=> reg_rdata[7:4] == 4'h0)
    else $error("cap reserved");
  // A second write between the two would legally change the data read back
  a_mbox_back: assert property (reg_wr && reg_addr == 8'h2e ##1 !reg_wr ##1 reg_rd
    && reg_addr == 8'h2e
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("mailbox");
  a_crc_write: assert property (reg_wr && reg_addr == 8'h21 && !second_port_select
    && bcc_load == 2'h0 ##1 bcc_load == 2'h0 |=> c0 == $past(w3, 2)) else $error("crc");
  a_load_lands: assert property (bcc_load[0] && !capability_freeze[0] && !reg_wr ##1 !reg_wr
    |=> c0 == $past(l3, 2)) else $error("load");
  a_freeze_holds: assert property ((capability_freeze[0] && !reg_wr) [*3] |-> $stable(c0))
    else $error("freeze");
  a_mode_legal: assert property (fast_control_channel_mode[2:1] != 2'b10
    && fast_control_channel_mode[5:4] != 2'b10) else $error("mode");
  a_link_rise: assert property (rx_valid |-> ##[1:3] link_detect) else $error("link");
endmodule

bind lcm_regs lcm_regs_chk i_chk (.*);

//--- lcm_far.sv
// Remote end model: capability loads and reverse-channel traffic
module lcm_far (
  input wire logic clk, // Clock
  input wire logic talk, // Traffic on
  output logic [1:0] bcc_load, // Load pulse
  output logic [3:0] bcc_cap2, // Load value
  output logic rx_valid // Traffic pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] n = 4'h0;
  initial {bcc_load, bcc_cap2, rx_valid} = 7'h0;
  // One pulse in 16 cycles, far inside every limit the bench sets
  always @(negedge clk) begin
    n <= n + 4'h1;
    rx_valid <= talk && n == 4'h0;
  end
  // Value idles inverted outside the pulse, so a stale value never passes
  task automatic load(input int p, input logic [3:0] v);
    @(negedge clk) {bcc_cap2, bcc_load[p]} = {v, 1'b1};
    @(negedge clk) {bcc_cap2, bcc_load} = {~v, 2'h0};
  endtask
endmodule

//--- lcm_regs_tb_top.sv
// Bench for the capability and mailbox registers
module lcm_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, sps = 0, wr = 0, rd = 0, talk = 0, rxv, link;
  logic [7:0] adr = 8'h0, wd = 8'h0, rdata, r;
  logic [1:0] ld, frz = 2'h0, cke = 2'h0, mb0 = 2'h0, crc;
  logic [3:0] cap;
  logic [5:0] mode, mode_s;
  logic [31:0] s = 32'h4f302d1f;
  int n_fail = 0, cmp_count = 0, k;
  lcm_regs #(.CNT0(28'h64), .CNT1(28'hc8)) i_dut (.clk(clk), .resetn(resetn),
    .second_port_select(sps), .reg_wr(wr), .reg_rd(rd), .reg_addr(adr), .reg_wdata(wd),
    .reg_rdata(rdata), .bcc_load(ld), .bcc_cap2(cap), .capability_freeze(frz),
    .chksum_err(cke), .mode_bit0(mb0), .rx_valid(rxv), .enhanced_crc_enable(crc),
    .fast_control_channel_mode(mode), .link_detect(link));
  // Single-link build sharing every input; only its mode output is looked at
  lcm_regs #(.DUAL_LINK(1'b0), .CNT0(28'h64), .CNT1(28'hc8)) i_dut_single (.clk(clk),
    .resetn(resetn), .second_port_select(sps), .reg_wr(wr), .reg_rd(rd), .reg_addr(adr),
    .reg_wdata(wd), .reg_rdata(), .bcc_load(ld), .bcc_cap2(cap), .capability_freeze(frz),
    .chksum_err(cke), .mode_bit0(mb0), .rx_valid(rxv), .enhanced_crc_enable(),
    .fast_control_channel_mode(mode_s), .link_detect());
  lcm_far i_far (.clk(clk), .talk(talk), .bcc_load(ld), .bcc_cap2(cap), .rx_valid(rxv));
  initial forever #4 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // Codes 100 and 101 decode to normal
  function automatic logic [7:0] dec(input int c);
    return (c / 2 == 2) ? 8'h0 : 8'(c);
  endfunction
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wt(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {wr, adr, wd} = {1'b1, a, d};
    @(negedge clk) wr = 0;
  endtask
  task automatic rt(input logic [7:0] a);
    @(negedge clk) {rd, adr} = {1'b1, a};
    @(negedge clk) rd = 0;
    @(negedge clk) r = rdata;
  endtask
  task automatic end_sim();
    $display("compares %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    resetn = 1;
    rt(8'h21); cmp(r, 8'h00);
    rt(8'h26); cmp(r, 8'h00);
    rt(8'h2e); cmp(r, 8'ha5);
    rt(8'h2f); cmp(r, 8'h5a);
    rt(8'h30); cmp(r, 8'h00);
    $display("reset test done");
    // Random scratch data; reserved bits and offsets must not disturb anything
    repeat (8) begin
      s = xs(s);
      wt(8'h2e, s[7:0]); rt(8'h2e); cmp(r, s[7:0]);
      wt(8'h2f, s[15:8]); wt(8'h26, s[23:16]); wt(8'h30, 8'hff);
      rt(8'h2f); cmp(r, s[15:8]);
      rt(8'h26); cmp(r, {5'h0, s[18:16]});
    end
    $display("scratch test done");
    // Every mode code on port 0 except 100 and 101, crc enable riding along
    for (int c = 0; c < 8; c++) begin
      if (c / 2 == 2) continue;
      mb0[0] = c[0];
      wt(8'h21, 8'(8 + c / 2));
      repeat (2) @(negedge clk);
      cmp({5'h0, mode[2:0]}, dec(c));
      cmp({6'h0, crc}, 8'h01);
      cmp({5'h0, mode_s[2:0]}, 8'h00);
    end
    sps = 1; wt(8'h21, 8'hf7); rt(8'h21); cmp(r, 8'h03);
    cmp({2'h0, mode}, 8'h37);
    cke = 2'b10; @(negedge clk) cke = 2'b00;
    wt(8'h21, 8'h03); rt(8'h21); cmp(r, 8'h07);
    sps = 0; rt(8'h21); cmp(r, 8'h0b);
    // Back-channel loads land only while unfrozen
    i_far.load(0, 4'h1); rt(8'h21); cmp(r, 8'h01);
    frz = 2'b01; i_far.load(0, 4'ha); rt(8'h21); cmp(r, 8'h01);
    $display("capability test done");
    // Link holds under traffic, drops only after the selected silence
    for (int t = 0; t < 2; t++) begin
      wt(8'h26, 8'(t)); talk = 1; repeat (40) @(negedge clk);
      talk = 0; repeat (80 + 100 * t) @(negedge clk); cmp({7'h0, link}, 8'h01);
      for (k = 0; k < 60 && link !== 1'b0; k++) @(negedge clk);
      cmp({7'h0, link}, 8'h00);
    end
    $display("link test done");
    end_sim();
  end
endmodule
